// [src/fault_log.v]
// Function
// R01: alarm opens drive-ready, servo off, estop self-clears
// R02: warning opens warning output, reaction per warning
// R03: warning cleared by input, command, power cycle
// R04: overtravel stops motor, opens direction output, blocks
// R05: host moves motor back out of limit
// R06: output polarity configurable, open-on-fault by default
// R07: indicator shows faults only in fault mode
// R08: status query lists active faults, none if clear
// R09: advance key steps, quit key ends readout
// R10: status list order need not follow occurrence
// R11: history keeps up to 32 records
// R12: full history drops oldest, appends newest
// R13: history numbered newest first from one
// R14: record holds fault code and sub-code
// R15: record holds elapsed time and power-on count
// R16: some codes never logged to history
// R17: cpu and rom logging decided per sub-code
// R18: home set logs a non-fault event record
// R19: circular buffer with write pointer and count
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fault_log_regs.vh"
module fault_log #(
  parameter DEPTH_LOG2 = 5,
  parameter TICKS_SEC = `FL_TICKS_SEC,
  parameter [15:0] WARN_STOP_MASK = 16'h0000
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // discrete pins from the host
  input wire emergency_stop_in,
  input wire fault_clear_in,
  input wire advance_key,
  input wire quit_key,
  input wire limit_plus_in,
  input wire limit_minus_in,
  // fault reports from servo logic
  input wire fault_valid,
  input wire [4:0] fault_idx,
  input wire [7:0] fault_sub,
  input wire home_return_done,
  input wire [15:0] power_on_count,
  input wire [7:0] io_state,
  // status outputs to the host
  output reg drive_ready_out,
  output reg warning_out,
  output reg overtravel_plus_out,
  output reg overtravel_minus_out,
  // servo reaction
  output reg servo_on,
  output reg motor_stop,
  output reg block_plus,
  output reg block_minus,
  // front indicator
  output reg [7:0] indicator_value,
  output reg indicator_fault_lit,
  // interrupt
  output reg irq
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  // readout states, one-hot
  localparam RO_IDLE = 3'h1;
  localparam RO_STAT = 3'h2;
  localparam RO_HIST = 3'h4;

  // first set bit at or above a start index, 32 if none
  function [5:0] next_set;
    input [31:0] v;
    input [5:0] from;
    integer i;
    begin
      next_set = 6'h20;
      for (i = 31; i >= 0; i = i - 1) begin
        if (v[i] && (i >= from))
          next_set = i[5:0];
      end
    end
  endfunction

  // whether a fault report is written to history
  function log_ok;
    input [4:0] ix;
    input [7:0] sub;
    begin
      case (ix)
        `FL_IX_RAM, `FL_IX_ESTOP, `FL_IX_UVOLT,
        `FL_IX_SWOT, `FL_IX_HWOT: log_ok = 1'b0; // R16
        `FL_IX_CPU, `FL_IX_ROM: log_ok = sub[`FL_SUB_LOG]; // R17
        default: log_ok = 1'b1;
      endcase
    end
  endfunction

  // pin synchronisers
  reg [5:0] pin_s1; // first stage
  reg [5:0] pin_s2; // second stage
  reg [5:0] pin_d; // delayed for edges
  wire estop = pin_s2[0];
  wire clr_rise = pin_s2[1] & ~pin_d[1];
  wire adv_rise = pin_s2[2] & ~pin_d[2];
  wire quit_rise = pin_s2[3] & ~pin_d[3];
  wire lim_p = pin_s2[4];
  wire lim_m = pin_s2[5];

  always @(posedge clk) begin
    if (rst) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      pin_d <= 6'h00;
    end else begin
      pin_s1 <= {limit_minus_in, limit_plus_in, quit_key, advance_key, fault_clear_in, emergency_stop_in};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // register state
  reg [1:0] ctrl; // polarity, indicator mode
  reg [3:0] irq_stat; // sticky events
  reg [3:0] irq_mask; // enables
  reg [5:0] cmd; // one-cycle command pulses
  reg [31:0] active; // active fault bitmap
  reg [31:0] time_sec; // elapsed seconds
  reg [31:0] sec_div; // tick divider

  // history store
  reg [7:0] h_code [0:DEPTH-1];
  reg [7:0] h_sub [0:DEPTH-1];
  reg [31:0] h_time [0:DEPTH-1];
  reg [15:0] h_pwr [0:DEPTH-1];
  reg [DEPTH_LOG2-1:0] wp; // next free slot
  reg [DEPTH_LOG2:0] h_count; // records held
  reg home_pend; // home event waiting

  // readout state
  reg [2:0] ro_state;
  reg [5:0] ro_pos; // bit index or record number
  reg [7:0] ro_code;
  reg [7:0] ro_sub;
  reg [31:0] ro_time;
  reg [15:0] ro_pwr;
  reg ro_valid;

  // fault classification
  wire fault_clear = clr_rise | cmd[`FL_CMD_CLEAR];
  wire [31:0] set_vec = fault_valid ? (32'h1 << fault_idx) : 32'h0;
  wire alarm_any = |active[15:0];
  wire warn_any = |active[31:16];
  wire warn_stop = |(active[31:16] & WARN_STOP_MASK);
  wire ot_any = active[`FL_IX_SWOT] | active[`FL_IX_HWOT];

  // elapsed time since power-on
  always @(posedge clk) begin
    if (rst) begin
      sec_div <= 32'h0;
      time_sec <= 32'h0;
    end else if (sec_div == TICKS_SEC - 1) begin
      sec_div <= 32'h0;
      time_sec <= time_sec + 32'h1;
    end else begin
      sec_div <= sec_div + 32'h1;
    end
  end

  // active fault bitmap; set beats clear
  reg [31:0] next_active;
  always @* begin
    next_active = active;
    if (fault_clear)
      next_active[31:16] = 16'h0; // R03
    next_active = next_active | set_vec;
    next_active[`FL_IX_ESTOP] = estop; // R01
    next_active[`FL_IX_HWOT] = lim_p | lim_m; // R04
  end

  always @(posedge clk) begin
    if (rst)
      active <= 32'h0; // R03
    else
      active <= next_active;
  end

  // history writes, one record a cycle
  wire log_fault = fault_valid & log_ok(fault_idx, fault_sub);
  wire home_ev = home_return_done | cmd[`FL_CMD_AZERO];
  wire log_home = ~log_fault & (home_pend | home_ev);
  wire log_any = log_fault | log_home;

  always @(posedge clk) begin
    if (log_any) begin
      h_code[wp] <= log_fault ? {3'h0, fault_idx} : `FL_CODE_HOME; // R14 R18
      h_sub[wp] <= log_fault ? fault_sub : 8'h00; // R14
      h_time[wp] <= time_sec; // R15
      h_pwr[wp] <= power_on_count; // R15
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wp <= {DEPTH_LOG2{1'b0}};
      h_count <= {(DEPTH_LOG2+1){1'b0}};
      home_pend <= 1'b0;
    end else begin
      home_pend <= log_fault & (home_pend | home_ev); // R18
      if (log_any) begin
        wp <= wp + 1'b1; // R12 R19
        if (h_count != DEPTH)
          h_count <= h_count + 1'b1; // R11
      end
    end
  end

  // readout walker
  wire [DEPTH_LOG2-1:0] rd_slot = wp - ro_pos[DEPTH_LOG2-1:0]; // R13 R19
  wire [5:0] stat_next = next_set(active, ro_pos + 6'h1);
  wire adv = adv_rise | cmd[`FL_CMD_ADV];
  wire quit = quit_rise | cmd[`FL_CMD_QUIT];

  always @(posedge clk) begin
    if (rst) begin
      ro_state <= RO_IDLE;
      ro_pos <= 6'h0;
    end else begin
      case (ro_state)
        RO_IDLE: begin
          if (cmd[`FL_CMD_STAT] && active != 32'h0) begin
            ro_state <= RO_STAT; // R08
            ro_pos <= next_set(active, 6'h0); // R10
          end else if (cmd[`FL_CMD_HIST] && h_count != 0) begin
            ro_state <= RO_HIST;
            ro_pos <= 6'h1; // R13
          end
        end
        RO_STAT: begin
          if (quit)
            ro_state <= RO_IDLE; // R09
          else if (adv) begin
            if (stat_next[5])
              ro_state <= RO_IDLE; // R09
            else
              ro_pos <= stat_next; // R09
          end
        end
        RO_HIST: begin
          if (quit)
            ro_state <= RO_IDLE; // R09
          else if (adv) begin
            if ({1'b0, ro_pos} >= {1'b0, h_count})
              ro_state <= RO_IDLE;
            else
              ro_pos <= ro_pos + 6'h1; // R09
          end
        end
        default: ro_state <= RO_IDLE;
      endcase
    end
  end

  // readout data registers
  always @(posedge clk) begin
    if (rst) begin
      ro_valid <= 1'b0;
      ro_code <= 8'h00;
      ro_sub <= 8'h00;
      ro_time <= 32'h0;
      ro_pwr <= 16'h0;
    end else if (ro_state == RO_HIST) begin
      ro_valid <= 1'b1;
      ro_code <= h_code[rd_slot];
      ro_sub <= h_sub[rd_slot];
      ro_time <= h_time[rd_slot];
      ro_pwr <= h_pwr[rd_slot];
    end else if (ro_state == RO_STAT && active[ro_pos[4:0]]) begin
      ro_valid <= 1'b1; // R08
      ro_code <= {3'h0, ro_pos[4:0]};
      ro_sub <= 8'h00;
      ro_time <= 32'h0;
      ro_pwr <= 16'h0;
    end else begin
      ro_valid <= 1'b0; // R08
      ro_code <= 8'h00;
      ro_sub <= 8'h00;
      ro_time <= 32'h0;
      ro_pwr <= 16'h0;
    end
  end

  // pin outputs and servo reaction
  wire pol = ctrl[`FL_CTRL_POL];
  wire [5:0] first_ix = next_set(active, 6'h0); // 32 when nothing is active
  always @(posedge clk) begin
    if (rst) begin
      drive_ready_out <= 1'b0;
      warning_out <= 1'b0;
      overtravel_plus_out <= 1'b0;
      overtravel_minus_out <= 1'b0;
      servo_on <= 1'b0;
      motor_stop <= 1'b1;
      block_plus <= 1'b0;
      block_minus <= 1'b0;
      indicator_value <= 8'h00;
      indicator_fault_lit <= 1'b0;
    end else begin
      drive_ready_out <= ~alarm_any ^ pol; // R01 R06
      warning_out <= ~warn_any ^ pol; // R02 R06
      overtravel_plus_out <= ~lim_p ^ pol; // R04 R06
      overtravel_minus_out <= ~lim_m ^ pol; // R04 R06
      servo_on <= ~alarm_any; // R01
      motor_stop <= alarm_any | ot_any | warn_stop; // R02 R04
      block_plus <= lim_p; // R04 R05
      block_minus <= lim_m; // R04 R05
      if (ctrl[`FL_CTRL_LED] == 1'b0) begin
        indicator_fault_lit <= active != 32'h0; // R07
        indicator_value <= {3'h0, first_ix[4:0]};
      end else begin
        indicator_fault_lit <= 1'b0; // R07
        indicator_value <= io_state;
      end
    end
  end

  // interrupt events
  wire [3:0] ev = {log_any, (lim_p | lim_m) & ~active[`FL_IX_HWOT],
    |(set_vec[31:16] & ~active[31:16]), |(next_active[15:0] & ~active[15:0])};

  // axi write path, address and data in any order
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;

  always @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= `FL_CTRL_RST;
      irq_mask <= `FL_IRQ_RST;
      cmd <= 6'h00;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready;
      s_axi_wready <= ~w_held & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      cmd <= 6'h00;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr)
          `FL_CTRL: if (w_strb[0]) ctrl <= w_data[1:0]; // R06 R07
          `FL_CMD: if (w_strb[0]) cmd <= w_data[5:0]; // R03
          `FL_IRQ_MASK: if (w_strb[0]) irq_mask <= w_data[3:0];
          `FL_ACTIVE, `FL_RDOUT, `FL_RDTIME, `FL_RDPWR,
          `FL_IRQ_STAT, `FL_HCOUNT: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
    end
  end

  // axi read path; status read clears, new events win
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire rd_clr = rd_go && (s_axi_araddr == `FL_IRQ_STAT);
  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      irq_stat <= `FL_IRQ_RST;
      irq <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      irq_stat <= (irq_stat & ~(rd_clr ? irq_stat : 4'h0)) | ev;
      irq <= |(irq_stat & irq_mask);
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `FL_CTRL: s_axi_rdata <= {30'h0, ctrl};
          `FL_CMD: s_axi_rdata <= 32'h0;
          `FL_ACTIVE: s_axi_rdata <= active;
          `FL_RDOUT: s_axi_rdata <= {ro_valid, 4'h0, ro_state, 2'h0, ro_pos, ro_sub, ro_code};
          `FL_RDTIME: s_axi_rdata <= ro_time;
          `FL_RDPWR: s_axi_rdata <= {16'h0, ro_pwr};
          `FL_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat};
          `FL_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
          `FL_HCOUNT: s_axi_rdata <= {26'h0, h_count};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end
  end
endmodule // fault_log

// [src/fault_log_regs.vh]
`ifndef FAULT_LOG_REGS_VH
`define FAULT_LOG_REGS_VH
// register byte offsets
`define FL_CTRL 8'h00
`define FL_CMD 8'h04
`define FL_ACTIVE 8'h08
`define FL_RDOUT 8'h0C
`define FL_RDTIME 8'h10
`define FL_RDPWR 8'h14
`define FL_IRQ_STAT 8'h18
`define FL_IRQ_MASK 8'h1C
`define FL_HCOUNT 8'h20
// control fields and reset value
`define FL_CTRL_POL 0
`define FL_CTRL_LED 1
`define FL_CTRL_RST 2'h0
// command bits, write one to act
`define FL_CMD_CLEAR 0
`define FL_CMD_STAT 1
`define FL_CMD_HIST 2
`define FL_CMD_AZERO 3
`define FL_CMD_ADV 4
`define FL_CMD_QUIT 5
// interrupt event bits
`define FL_EV_ALARM 0
`define FL_EV_WARN 1
`define FL_EV_OT 2
`define FL_EV_LOG 3
`define FL_IRQ_RST 4'h0
// fault indices: 0..15 alarms, 16..31 warnings
`define FL_IX_CPU 5'h06
`define FL_IX_RAM 5'h08
`define FL_IX_ROM 5'h09
`define FL_IX_ESTOP 5'h0D
`define FL_IX_UVOLT 5'h0F
`define FL_IX_SWOT 5'h10
`define FL_IX_HWOT 5'h11
`define FL_SUB_LOG 7
`define FL_CODE_HOME 8'h80
// timing: one second of elapsed time
`define FL_SEC_NS 1000000000
`define FL_CLK_NS 10
`define FL_TICKS_SEC (`FL_SEC_NS / `FL_CLK_NS)
`endif

// [test/fault_log_assertions.sv]
`timescale 1ns/1ps
module fault_log_assertions (
  // clock and reset
  input wire clk,
  input wire rst,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // pins and reactions
  input wire emergency_stop_in,
  input wire limit_plus_in,
  input wire limit_minus_in,
  input wire servo_on,
  input wire motor_stop,
  input wire block_plus,
  input wire block_minus,
  input wire overtravel_plus_out,
  input wire overtravel_minus_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // address and data taken together
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // one limit held past the synchroniser, bitmap and block register; plus_held also past the stop register
  sequence plus_held;
    (limit_plus_in && !limit_minus_in) [*5];
  endsequence
  sequence minus_held;
    (limit_minus_in && !limit_plus_in) [*4];
  endsequence
  chk_write_answer: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_estop_servo: assert property (emergency_stop_in [*5] |-> !servo_on && motor_stop)
    else $error("estop left servo on");
  chk_alarm_stops: assert property (!servo_on |-> motor_stop)
    else $error("servo off without stop");
  chk_plus_block: assert property (plus_held |-> block_plus && motor_stop && overtravel_plus_out != overtravel_minus_out)
    else $error("plus limit not handled");
  chk_minus_block: assert property (minus_held |-> block_minus && !block_plus && overtravel_plus_out != overtravel_minus_out)
    else $error("minus limit not handled");
  chk_limit_free: assert property ((!limit_plus_in && !limit_minus_in) [*4] |-> !block_plus && !block_minus)
    else $error("block kept after limit left");
endmodule // fault_log_assertions
bind fault_log fault_log_assertions chk (.*);

// [test/host_model.sv]
`timescale 1ns/1ps
module host_model (
  // clock and reset
  input wire clk,
  input wire rst,
  // bench requests
  input wire go_plus,
  input wire go_minus,
  input wire [3:0] back_delay,
  // device reaction
  input wire block_plus,
  input wire block_minus,
  // limit switches
  output reg limit_plus_in,
  output reg limit_minus_in
);
  reg [3:0] wait_cnt; // cycles before backing out
  // drive into a limit, then move back out once blocked
  always @(posedge clk) begin
    if (rst) begin
      limit_plus_in <= 1'b0;
      limit_minus_in <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (go_plus || go_minus) begin
      limit_plus_in <= go_plus;
      limit_minus_in <= go_minus;
      wait_cnt <= back_delay;
    end else if ((block_plus && limit_plus_in) || (block_minus && limit_minus_in)) begin
      if (wait_cnt == 4'h0) begin
        limit_plus_in <= 1'b0;
        limit_minus_in <= 1'b0;
      end else begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule // host_model

// [test/fault_log_bench.sv]
`timescale 1ns/1ps
`include "fault_log_regs.vh"
`define CHK(g, x) cmp(g, x);
module fault_log_bench;
  localparam [31:0] ALL = 32'hFFFFFFFF;
  localparam [31:0] VM = 32'h803FFF00; // valid, position, sub-code
  // clock, reset, bus
  reg clk = 0, rst = 1;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  // pins and servo-side inputs
  reg emergency_stop_in = 0, fault_valid = 0, home_return_done = 0, go_plus = 0, go_minus = 0;
  reg [2:0] keys = 0; // quit, advance, clear
  reg [4:0] fault_idx = 0;
  reg [7:0] fault_sub = 0, io_state = 0;
  reg [15:0] power_on_count = 16'h0007;
  reg [3:0] back_delay = 4'h8;
  wire limit_plus_in, limit_minus_in;
  // outputs
  wire drive_ready_out, warning_out, overtravel_plus_out, overtravel_minus_out, servo_on, motor_stop;
  wire block_plus, block_minus, indicator_fault_lit, irq;
  wire [7:0] indicator_value;
  // bench state
  integer err_total = 0, num_checks = 0, guard, k, hc, seed = 90;
  reg [65:0] exp_q[$]; // mask, value, resp
  reg [65:0] e;
  reg [7:0] subs[0:33];
  fault_log #(.TICKS_SEC(10)) DUT (.*, .fault_clear_in(keys[0]), .advance_key(keys[1]), .quit_key(keys[2]));
  host_model model (.*);
  task cmp(input [65:0] g, input [65:0] x);
    begin
      num_checks = num_checks + 1;
      if (g !== x) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: %h vs %h", $time, g, x);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // bounded wait for one edge
  task tick;
    begin
      @(posedge clk);
      guard = guard + 1;
      if (guard > 300) begin
        err_total = err_total + 1;
        close_out;
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // bus write, response code compared
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      guard = 0;
      do begin
        tick;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      `CHK(s_axi_bresp, r)
      s_axi_bready <= 1'b0;
      @(posedge clk);
    end
  endtask
  // bus read, expectation queued for the monitor
  task rd(input [7:0] a, input [31:0] m, input [31:0] v, input [1:0] r);
    begin
      exp_q.push_back({m, v & m, r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      guard = 0;
      do begin
        tick;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge clk);
    end
  endtask
  task flt(input [4:0] i, input [7:0] s);
    begin
      fault_idx <= i;
      fault_sub <= s;
      fault_valid <= 1'b1;
      @(posedge clk);
      fault_valid <= 1'b0;
      @(posedge clk);
    end
  endtask
  task press(input integer b);
    begin
      keys[b] <= 1'b1;
      idle(4);
      keys[b] <= 1'b0;
      idle(4);
    end
  endtask
  // read data checked against the oldest note
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = exp_q.pop_front();
      `CHK({s_axi_rdata & e[65:34], s_axi_rresp}, e[33:0])
    end
  end
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    idle(2);
    rst <= 1'b0;
    idle(4);
    `CHK({drive_ready_out, warning_out, servo_on, irq}, 4'hE)
    rd(`FL_CTRL, ALL, 32'h0, 2'h0);
    rd(`FL_HCOUNT, ALL, 32'h0, 2'h0);
    rd(8'h24, ALL, 32'h0, 2'h2);
    wr(8'h24, 32'h1, 2'h2);
    wr(`FL_CMD, 32'h2, 2'h0);
    rd(`FL_RDOUT, 32'h80000000, 32'h0, 2'h0);
    // warning, interrupt, history readout
    wr(`FL_IRQ_MASK, 32'hF, 2'h0);
    flt(5'h14, 8'h5A);
    idle(4);
    `CHK({warning_out, irq, servo_on, motor_stop}, 4'h6)
    rd(`FL_IRQ_STAT, ALL, 32'hA, 2'h0);
    rd(`FL_IRQ_STAT, ALL, 32'h0, 2'h0);
    `CHK(irq, 1'b0)
    wr(`FL_CMD, 32'h4, 2'h0);
    rd(`FL_RDOUT, VM, 32'h80015A00, 2'h0);
    rd(`FL_RDPWR, 32'hFFFF, 32'h7, 2'h0);
    wr(`FL_CMD, 32'h20, 2'h0);
    rd(`FL_RDOUT, 32'h80000000, 32'h0, 2'h0);
    // status list of two warnings
    flt(5'h19, 8'h33);
    wr(`FL_CMD, 32'h2, 2'h0);
    rd(`FL_RDOUT, 32'h80000000, 32'h80000000, 2'h0);
    press(1);
    rd(`FL_RDOUT, 32'h80000000, 32'h80000000, 2'h0);
    press(2);
    rd(`FL_RDOUT, 32'h80000000, 32'h0, 2'h0);
    // polarity, clearing, indicator
    wr(`FL_CTRL, 32'h1, 2'h0);
    idle(4);
    `CHK({warning_out, drive_ready_out}, 2'h2)
    wr(`FL_CTRL, 32'h0, 2'h0);
    wr(`FL_CMD, 32'h1, 2'h0);
    idle(4);
    `CHK(warning_out, 1'b1)
    flt(5'h14, 8'h01);
    press(0);
    `CHK(warning_out, 1'b1)
    io_state <= $random(seed);
    wr(`FL_CTRL, 32'h2, 2'h0);
    idle(4);
    `CHK({indicator_value, indicator_fault_lit}, {io_state, 1'b0})
    wr(`FL_CTRL, 32'h0, 2'h0);
    // estop, then limits with their interrupt masked
    emergency_stop_in <= 1'b1;
    idle(5);
    `CHK({servo_on, drive_ready_out, motor_stop}, 3'h1)
    emergency_stop_in <= 1'b0;
    idle(5);
    `CHK({servo_on, drive_ready_out}, 2'h3)
    wr(`FL_IRQ_MASK, 32'h3, 2'h0);
    rd(`FL_IRQ_STAT, ALL, 32'hB, 2'h0);
    go_plus <= 1'b1;
    @(posedge clk);
    go_plus <= 1'b0;
    idle(5);
    `CHK({block_plus, block_minus, overtravel_plus_out, overtravel_minus_out, motor_stop}, 5'h13)
    idle(20);
    `CHK({block_plus, limit_plus_in, irq}, 3'h0)
    back_delay <= 4'h0;
    go_minus <= 1'b1;
    @(posedge clk);
    go_minus <= 1'b0;
    idle(20);
    `CHK(block_minus, 1'b0)
    rd(`FL_IRQ_STAT, 32'h4, 32'h4, 2'h0);
    hc = 3;
    rd(`FL_HCOUNT, ALL, hc, 2'h0);
    // home events
    wr(`FL_CMD, 32'h8, 2'h0);
    home_return_done <= 1'b1;
    @(posedge clk);
    home_return_done <= 1'b0;
    wr(`FL_CMD, 32'h4, 2'h0);
    rd(`FL_RDOUT, 32'h803FFFFF, 32'h80010080, 2'h0);
    wr(`FL_CMD, 32'h10, 2'h0);
    rd(`FL_RDOUT, 32'h003F00FF, 32'h00020080, 2'h0);
    wr(`FL_CMD, 32'h20, 2'h0);
    hc = hc + 2;
    // codes kept out of the history, cpu and rom by sub-code
    flt(`FL_IX_RAM, 8'h00);
    flt(`FL_IX_ESTOP, 8'h00);
    flt(`FL_IX_UVOLT, 8'h00);
    flt(`FL_IX_CPU, 8'h7F);
    flt(`FL_IX_ROM, 8'h01);
    rd(`FL_HCOUNT, ALL, hc, 2'h0);
    flt(`FL_IX_CPU, 8'h80);
    flt(`FL_IX_ROM, 8'hFF);
    rd(`FL_HCOUNT, ALL, hc + 2, 2'h0);
    rd(`FL_ACTIVE, 32'h340, 32'h340, 2'h0);
    `CHK({servo_on, drive_ready_out}, 2'h0)
    `CHK({indicator_value, indicator_fault_lit}, {8'h06, 1'b1})
    // overfill, then walk all 32 records newest first
    power_on_count <= 16'h0123;
    for (k = 0; k < 34; k = k + 1) begin
      subs[k] = $random(seed);
      flt(5'(18 + k % 14), subs[k]);
    end
    rd(`FL_HCOUNT, ALL, 32'd32, 2'h0);
    wr(`FL_CMD, 32'h4, 2'h0);
    for (k = 1; k < 33; k = k + 1) begin
      rd(`FL_RDOUT, VM, {10'h200, k[5:0], subs[34 - k], 8'h0}, 2'h0);
      rd(`FL_RDPWR, 32'hFFFF, 32'h0123, 2'h0);
      press(1);
    end
    rd(`FL_RDOUT, 32'h80000000, 32'h0, 2'h0);
    close_out;
  end
endmodule // fault_log_bench
